// ===== hw/rx_ctl_tx_status.v
// receive-control gating and transmit-status register block
`timescale 1ns/100ps
`include "rxq_ctl_defs.vh"

// Summary of operation
// - late collision sets late-collision status flag
// - max collisions sets max-collision status flag
// - six-bit frame id, status matches frame
// - flush clears queue and frame pointer
// - udp checksum check drops bad frames
// - tcp checksum check drops bad frames
// - ip header checksum check drops bad
// - physical filter accepts matched unicast, default one
// - full-duplex pause holds transmit until expiry
// - error-frame enable stores crc errors, else drops
// - multicast filter accepts matched multicast frames
// - broadcast accept passes every broadcast address unless inverse filter is set
// - all-multicast receives multicast including broadcast
// - unicast accept matches own station address
// - accept-all passes every address; crc, checksum and pause drops still apply
// - inverse filter inverts address decision
// - enable runs; disable stops after current frame
module rx_ctl_tx_status #(
    parameter PAUSE_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register port
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // transmit completion report
    input wire tx_done,
    input wire [`FID_W-1:0] tx_done_fid,
    input wire tx_done_late_col,
    input wire tx_done_max_col,
    // received frame descriptor, valid on rx_end
    input wire full_duplex,
    input wire rx_start,
    input wire rx_end,
    input wire [47:0] rx_dest_addr,
    input wire [47:0] station_addr,
    input wire rx_filter_hit,
    input wire rx_crc_err,
    input wire rx_is_ip,
    input wire rx_ip_chk_bad,
    input wire rx_is_tcp,
    input wire rx_tcp_chk_bad,
    input wire rx_is_udp,
    input wire rx_udp_chk_bad,
    input wire rx_is_pause,
    input wire [PAUSE_W-1:0] rx_pause_quanta,
    // quanta tick from the mac timebase
    input wire pause_tick,
    // outcome to the queue, transmit hold and receive run status
    output reg rx_store,
    output reg rx_drop,
    output reg rx_queue_clear,
    output reg tx_hold,
    output reg rx_running
);

    reg [15:0] rx_control_one_r;
    reg tx_late_collision_flag_r;
    reg tx_max_collision_flag_r;
    reg [`FID_W-1:0] tx_frame_identifier_r;
    reg [`PTR_W-1:0] rx_frame_ptr_r;
    reg [`CNT_W-1:0] rx_frame_cnt_r;
    reg [PAUSE_W-1:0] pause_cnt_r;
    reg in_frame_r;
    reg [15:0] rdata_nxt;
    reg accept_nxt;
    reg addr_ok;

    wire rx_queue_flush = rx_control_one_r[`B_FLUSH];
    wire rx_udp_checksum_check_en = rx_control_one_r[`B_UDP_CHK];
    wire rx_tcp_checksum_check_en = rx_control_one_r[`B_TCP_CHK];
    wire rx_ip_checksum_check_en = rx_control_one_r[`B_IP_CHK];
    wire rx_physical_addr_filter_en = rx_control_one_r[`B_PHYS_FILT];
    wire rx_flow_control_en = rx_control_one_r[`B_FLOW_CTL];
    wire rx_error_frame_accept = rx_control_one_r[`B_ERR_FRAME];
    wire rx_multicast_filter_en = rx_control_one_r[`B_MCAST_FILT];
    wire rx_broadcast_accept = rx_control_one_r[`B_BCAST];
    wire rx_all_multicast_accept = rx_control_one_r[`B_ALL_MCAST];
    wire rx_unicast_accept = rx_control_one_r[`B_UCAST];
    wire rx_accept_all = rx_control_one_r[`B_ALL];
    wire rx_inverse_filter = rx_control_one_r[`B_INV];
    wire rx_block_enable = rx_control_one_r[`B_RX_EN];

    wire is_bcast = &rx_dest_addr;
    wire is_mcast = rx_dest_addr[`B_GROUP_ADDR];
    wire own_match = (rx_dest_addr == station_addr);

    // address decision; inverse mode flips the match terms but not accept-all
    always @* begin
        addr_ok = 1'b0;
        if (is_bcast) begin
            addr_ok = rx_broadcast_accept | rx_all_multicast_accept;
        end else if (is_mcast) begin
            addr_ok = rx_all_multicast_accept | (rx_multicast_filter_en & rx_filter_hit);
        end else begin
            addr_ok = (rx_unicast_accept & own_match) | (rx_physical_addr_filter_en & rx_filter_hit);
        end
        if (rx_inverse_filter) begin
            addr_ok = ~addr_ok;
        end
        if (rx_accept_all) begin
            addr_ok = 1'b1;
        end
    end

    always @* begin
        accept_nxt = addr_ok;
        if (rx_crc_err & ~rx_error_frame_accept) begin
            accept_nxt = 1'b0;
        end
        if (rx_ip_checksum_check_en & rx_is_ip & rx_ip_chk_bad) begin
            accept_nxt = 1'b0;
        end
        if (rx_tcp_checksum_check_en & rx_is_tcp & rx_tcp_chk_bad) begin
            accept_nxt = 1'b0;
        end
        if (rx_udp_checksum_check_en & rx_is_udp & rx_udp_chk_bad) begin
            accept_nxt = 1'b0;
        end
        // pause frames are consumed by flow control, never queued
        if (rx_is_pause) begin
            accept_nxt = 1'b0;
        end
    end

    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `OFF_TX_LAST_FRAME_STATUS: begin
                rdata_nxt[`B_LATE_COL] = tx_late_collision_flag_r;
                rdata_nxt[`B_MAX_COL] = tx_max_collision_flag_r;
                rdata_nxt[`FID_HI:`FID_LO] = tx_frame_identifier_r;
            end
            `OFF_RX_CONTROL_ONE: rdata_nxt = rx_control_one_r;
            `OFF_RX_FRAME_COUNT: rdata_nxt[`CNT_W-1:0] = rx_frame_cnt_r;
            `OFF_RX_LINK_STATUS: rdata_nxt = rx_frame_ptr_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
            rx_control_one_r <= `RXC1_RESET;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
            if (reg_wr && reg_addr == `OFF_RX_CONTROL_ONE) begin
                rx_control_one_r <= reg_wdata & `RXC1_WMASK;
            end
        end
    end

    // whole status word loads at once from the completion report
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_late_collision_flag_r <= 1'b0;
            tx_max_collision_flag_r <= 1'b0;
            tx_frame_identifier_r <= {`FID_W{1'b0}};
        end else if (tx_done) begin
            tx_late_collision_flag_r <= tx_done_late_col;
            tx_max_collision_flag_r <= tx_done_max_col;
            tx_frame_identifier_r <= tx_done_fid;
        end
    end

    // a frame in progress finishes even if enable drops mid-frame
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_frame_r <= 1'b0;
            rx_running <= 1'b0;
        end else begin
            if (rx_start && rx_block_enable && !rx_queue_flush) begin
                in_frame_r <= 1'b1;
            end else if (rx_end || rx_queue_flush) begin
                in_frame_r <= 1'b0;
            end
            rx_running <= rx_block_enable | (in_frame_r & ~rx_end);
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_store <= 1'b0;
            rx_drop <= 1'b0;
            rx_queue_clear <= 1'b0;
            rx_frame_ptr_r <= {`PTR_W{1'b0}};
            rx_frame_cnt_r <= {`CNT_W{1'b0}};
        end else begin
            rx_store <= 1'b0;
            rx_drop <= 1'b0;
            rx_queue_clear <= rx_queue_flush;
            if (rx_queue_flush) begin
                rx_frame_ptr_r <= {`PTR_W{1'b0}};
                rx_frame_cnt_r <= {`CNT_W{1'b0}};
            end else if (rx_end && in_frame_r) begin
                if (accept_nxt) begin
                    rx_store <= 1'b1;
                    rx_frame_ptr_r <= rx_frame_ptr_r + {{(`PTR_W-1){1'b0}}, 1'b1};
                    rx_frame_cnt_r <= rx_frame_cnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
                end else begin
                    rx_drop <= 1'b1;
                end
            end
        end
    end

    // pause honoured only in full duplex with flow control on
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pause_cnt_r <= {PAUSE_W{1'b0}};
            tx_hold <= 1'b0;
        end else begin
            if (rx_end && in_frame_r && rx_is_pause && !rx_crc_err && rx_flow_control_en && full_duplex) begin
                pause_cnt_r <= rx_pause_quanta;
                tx_hold <= (rx_pause_quanta != {PAUSE_W{1'b0}});
            end else if (pause_tick && pause_cnt_r != {PAUSE_W{1'b0}}) begin
                pause_cnt_r <= pause_cnt_r - {{(PAUSE_W-1){1'b0}}, 1'b1};
                tx_hold <= (pause_cnt_r != {{(PAUSE_W-1){1'b0}}, 1'b1});
            end
        end
    end

endmodule // rx_ctl_tx_status

// ===== hw/rxq_ctl_defs.vh
// register offsets, field positions and reset values for rx control / tx status
`ifndef RXQ_CTL_DEFS_VH
`define RXQ_CTL_DEFS_VH
`define ADDR_W 8
`define OFF_TX_LAST_FRAME_STATUS 8'h72
`define OFF_RX_CONTROL_ONE 8'h74
`define OFF_RX_FRAME_COUNT 8'h80
`define OFF_RX_LINK_STATUS 8'h82
`define B_LATE_COL 13
`define B_MAX_COL 12
`define FID_HI 5
`define FID_LO 0
`define B_FLUSH 15
`define B_UDP_CHK 14
`define B_TCP_CHK 13
`define B_IP_CHK 12
`define B_PHYS_FILT 11
`define B_FLOW_CTL 10
`define B_ERR_FRAME 9
`define B_MCAST_FILT 8
`define B_BCAST 7
`define B_ALL_MCAST 6
`define B_UCAST 5
`define B_ALL 4
`define B_INV 1
`define B_RX_EN 0
`define B_GROUP_ADDR 40
`define RXC1_RESET 16'h0800
`define RXC1_WMASK 16'hFFF3
`define FID_W 6
`define PTR_W 16
`define CNT_W 8
`endif

// ===== tb/rx_ctl_tx_status_props.sv
// port assertions for rx control gating and tx status
`timescale 1ns/100ps
`include "rxq_ctl_defs.vh"
module rx_ctl_tx_status_props (
    input wire clk, input wire rst_b,
    input wire [`ADDR_W-1:0] reg_addr, input wire [15:0] reg_wdata, input wire reg_wr, input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire tx_done, input wire [`FID_W-1:0] tx_done_fid, input wire tx_done_late_col, input wire tx_done_max_col,
    input wire full_duplex, input wire rx_end, input wire rx_is_pause,
    input wire rx_store, input wire rx_drop, input wire rx_queue_clear, input wire tx_hold
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire mapped = reg_addr == 8'h72 || reg_addr == 8'h74 || reg_addr == 8'h80 || reg_addr == 8'h82;
    store_cause_a: assert property (rx_store |-> $past(rx_end)) else $error("store without frame end");
    drop_cause_a: assert property (rx_drop |-> $past(rx_end)) else $error("drop without frame end");
    one_verdict_a: assert property (!(rx_store && rx_drop)) else $error("store and drop together");
    status_read_a: assert property (tx_done ##1 (reg_rd && reg_addr == 8'h72) |=> reg_rdata == {2'b00,
        $past(tx_done_late_col, 2), $past(tx_done_max_col, 2), 6'h00, $past(tx_done_fid, 2)})
        else $error("tx status differs from last frame");
    flush_clear_a: assert property (reg_wr && reg_addr == 8'h74 && reg_wdata[15] |=> ##1 rx_queue_clear)
        else $error("flush did not clear queue");
    hold_cause_a: assert property ($rose(tx_hold) |-> $past(rx_end) && $past(rx_is_pause) && $past(full_duplex))
        else $error("hold without full duplex pause");
    unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000) else $error("unmapped read not 0");
    rdata_stands_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule // rx_ctl_tx_status_props
bind rx_ctl_tx_status rx_ctl_tx_status_props u_props (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done),
    .tx_done_fid(tx_done_fid), .tx_done_late_col(tx_done_late_col), .tx_done_max_col(tx_done_max_col),
    .full_duplex(full_duplex), .rx_end(rx_end), .rx_is_pause(rx_is_pause), .rx_store(rx_store),
    .rx_drop(rx_drop), .rx_queue_clear(rx_queue_clear), .tx_hold(tx_hold));

// ===== tb/frame_source.sv
// remote station model: frame descriptors as seen through the phy
`timescale 1ns/100ps
module frame_source (
    input wire clk,
    output reg rx_start = 1'b0,
    output reg rx_end = 1'b0,
    output reg [47:0] dest = 48'h0,
    output reg [8:0] fl = 9'h0
);
    // fields mean nothing off rx_end; invert them so stale values never pass
    task send(input [47:0] d, input [8:0] f);
        begin
            @(posedge clk);
            rx_start <= 1'b1;
            @(posedge clk);
            rx_start <= 1'b0;
            @(posedge clk);
            rx_end <= 1'b1;
            dest <= d;
            fl <= f;
            @(posedge clk);
            rx_end <= 1'b0;
            dest <= ~d;
            fl <= ~f;
        end
    endtask
endmodule // frame_source

// ===== tb/test_rx_ctl_tx_status.sv
// self-checking bench for rx control gating and tx status
`timescale 1ns/100ps
`include "rxq_ctl_defs.vh"
module test_rx_ctl_tx_status;
    localparam [47:0] st = 48'h021122334455;
    localparam [47:0] uc = 48'h02AABBCCDDEE;
    localparam [47:0] mc = 48'h01005E000001;
    localparam [47:0] bc = 48'hFFFFFFFFFFFF;
    reg clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_done = 1'b0, lc = 1'b0, mcol = 1'b0;
    reg fd = 1'b1, tick_p = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [15:0] reg_wdata = 16'h0000;
    reg [5:0] fid = 6'h00;
    wire [15:0] reg_rdata;
    wire rx_start, rx_end, rx_store, rx_drop, rx_queue_clear, tx_hold, rx_running;
    wire [47:0] dest;
    wire [8:0] fl;
    integer fails = 0, n_tests = 0, n_acc = 0;
    frame_source u_frame_source (.clk(clk), .rx_start(rx_start), .rx_end(rx_end), .dest(dest), .fl(fl));
    rx_ctl_tx_status u_rx_ctl_tx_status (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done), .tx_done_fid(fid),
        .tx_done_late_col(lc), .tx_done_max_col(mcol), .full_duplex(fd), .rx_start(rx_start), .rx_end(rx_end),
        .rx_dest_addr(dest), .station_addr(st), .rx_filter_hit(fl[0]), .rx_crc_err(fl[1]), .rx_is_ip(fl[2]),
        .rx_ip_chk_bad(fl[3]), .rx_is_tcp(fl[4]), .rx_tcp_chk_bad(fl[5]), .rx_is_udp(fl[6]),
        .rx_udp_chk_bad(fl[7]), .rx_is_pause(fl[8]), .rx_pause_quanta(16'h0002), .pause_tick(tick_p),
        .rx_store(rx_store), .rx_drop(rx_drop), .rx_queue_clear(rx_queue_clear), .tx_hold(tx_hold),
        .rx_running(rx_running));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, e);
        end
    endtask
    task fr(input [15:0] c, input [47:0] d, input [8:0] f, input [1:0] e);
        begin
            wr(8'h74, c);
            u_frame_source.send(d, f);
            #1 chk({14'h0, rx_store, rx_drop}, {14'h0, e});
            n_acc = n_acc + e[1];
        end
    endtask
    task pulse_tick;
        begin
            tick_p <= 1'b1;
            @(posedge clk);
            tick_p <= 1'b0;
            #1 chk({15'h0, tx_hold}, 16'h0001);
        end
    endtask
    task txd(input [5:0] f, input l, input m);
        begin
            tx_done <= 1'b1;
            fid <= f;
            lc <= l;
            mcol <= m;
            @(posedge clk);
            tx_done <= 1'b0;
            fid <= ~f;
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h74, 16'h0800);
        rd(8'h72, 16'h0000);
        wr(8'h74, 16'h7FFF);
        rd(8'h74, 16'h7FF3);
        chk({15'h0, rx_running}, 16'h0001);
        wr(8'h72, 16'hFFFF);
        rd(8'h72, 16'h0000);
        rd(8'h90, 16'h0000);
        $display("registers done");
        fr(16'h0020, st, 9'h000, 2'b00);
        fr(16'h0021, st, 9'h000, 2'b10);
        fr(16'h0021, uc, 9'h000, 2'b01);
        fr(16'h0081, bc, 9'h000, 2'b10);
        fr(16'h0041, mc, 9'h000, 2'b10);
        fr(16'h0041, bc, 9'h000, 2'b10);
        fr(16'h0011, uc, 9'h000, 2'b10);
        fr(16'h0101, mc, 9'h001, 2'b10);
        fr(16'h0101, mc, 9'h000, 2'b01);
        fr(16'h0801, uc, 9'h001, 2'b10);
        fr(16'h0023, st, 9'h000, 2'b01);
        fr(16'h0023, uc, 9'h000, 2'b10);
        fr(16'h0011, uc, 9'h002, 2'b01);
        fr(16'h0211, uc, 9'h002, 2'b10);
        fr(16'h1011, uc, 9'h00C, 2'b01);
        fr(16'h0011, uc, 9'h00C, 2'b10);
        fr(16'h2011, uc, 9'h030, 2'b01);
        fr(16'h4011, uc, 9'h0C0, 2'b01);
        fr(16'h4011, uc, 9'h040, 2'b10);
        fork
            u_frame_source.send(uc, 9'h000);
            begin
                repeat (2) @(posedge clk);
                wr(8'h74, 16'h0010);
            end
        join
        #1 chk({14'h0, rx_store, rx_drop}, 16'h0002);
        chk({15'h0, rx_running}, 16'h0000);
        n_acc = n_acc + 1;
        fr(16'h0411, uc, 9'h100, 2'b01);
        pulse_tick;
        tick_p <= 1'b1;
        @(posedge clk);
        tick_p <= 1'b0;
        @(posedge clk);
        #1 chk({15'h0, tx_hold}, 16'h0000);
        fd <= 1'b0;
        fr(16'h0011, uc, 9'h100, 2'b01);
        chk({15'h0, tx_hold}, 16'h0000);
        $display("frames done");
        rd(8'h80, n_acc[15:0]);
        rd(8'h82, n_acc[15:0]);
        wr(8'h74, 16'h0000);
        wr(8'h74, 16'h8000);
        @(posedge clk);
        #1 chk({15'h0, rx_queue_clear}, 16'h0001);
        rd(8'h80, 16'h0000);
        rd(8'h82, 16'h0000);
        wr(8'h74, 16'h0000);
        $display("flush done");
        txd(6'h2A, 1'b1, 1'b0);
        rd(8'h72, 16'h202A);
        txd(6'h0F, 1'b0, 1'b1);
        rd(8'h72, 16'h100F);
        $display("tx status done");
        end_of_test;
    end
endmodule // test_rx_ctl_tx_status
